// ===== verilog/flash_seq_defines.svh
// Constants for the flash command sequencer: offsets, fields, codes and timing.
`ifndef FLASH_SEQ_DEFINES_SVH
`define FLASH_SEQ_DEFINES_SVH

// ****************************************
// Register map, byte addresses.
// ****************************************
`define CTRL_A_OFFSET       16'h0000
`define CTRL_B_OFFSET       16'h0004
`define ROM_BASE            16'h8000

// ****************************************
// Field positions.
// ****************************************
`define CA_READY_BIT        0
`define CA_LOCK_DISABLE_BIT 2
`define CA_PROG_ERR_BIT     6
`define CA_ERASE_ERR_BIT    7
`define CB_EW_MODE_BIT      1
`define CB_LOCK_RESULT_BIT  6
`define CB_CLK_STOP_BIT     8
`define SR_READY_BIT        7
`define SR_ERASE_ERR_BIT    5
`define SR_PROG_ERR_BIT     4

// ****************************************
// Command codes, low byte only.
// ****************************************
`define CMD_READ_ARRAY      8'hFF
`define CMD_READ_STATUS     8'h70
`define CMD_CLEAR_STATUS    8'h50
`define CMD_PROGRAM         8'h40
`define CMD_BLOCK_ERASE     8'h20
`define CMD_ERASE_ALL       8'hA7
`define CMD_LOCK_PROGRAM    8'h77
`define CMD_READ_LOCK       8'h71
`define CMD_CONFIRM         8'hD0

// ****************************************
// Geometry, reset values and timing.
// ****************************************
`define NUM_BLOCKS          14
`define BLOCK_A_INDEX       13
`define BLOCK_WORDS_LOG2    8
`define ARRAY_ADDR_BITS     12
`define LOCK_RESET          14'h3FFF
`define PROGRAM_TIME_NS     400
`define ERASE_TIME_NS       4000
`define CLK_PERIOD_NS       4

`endif

// ===== verilog/flash_seq_pkg.sv
// Types shared by the flash command sequencer.
package flash_seq_pkg;

    typedef enum logic [1:0] {
        MODE_ARRAY,
        MODE_STATUS,
        MODE_SECOND
    } read_mode_e;

    typedef enum logic [2:0] {
        OP_IDLE,
        OP_PROGRAM,
        OP_ERASE,
        OP_ERASE_ALL,
        OP_LOCK_PROGRAM,
        OP_READ_LOCK
    } op_e;

endpackage

// ===== verilog/op_timer.sv
// Down counter that times one auto program or auto erase step.
`include "flash_seq_defines.svh"

module op_timer #(
    parameter int WIDTH = 16
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             start,
    input  wire logic [WIDTH-1:0] load,
    output logic                  done
);

    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic             running;
        logic             done;
    } timer_s;

    timer_s state;
    timer_s next_state;

    always_comb begin
        next_state = state;
        next_state.done = 1'b0;
        if (start) begin
            next_state.count = load;
            next_state.running = 1'b1;
        end else if (state.running) begin
            if (state.count <= WIDTH'(1)) begin
                next_state.running = 1'b0;
                next_state.done = 1'b1;
            end else begin
                next_state.count = state.count - WIDTH'(1);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign done = state.done;

endmodule

// ===== verilog/flash_command_sequencer.sv
// Flash command interpreter and auto program/erase sequencer behind AHB-Lite.
`include "flash_seq_defines.svh"

module flash_command_sequencer #(
    parameter int PROGRAM_CYCLES = (`PROGRAM_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int ERASE_CYCLES   = (`ERASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int NUM_BLOCKS     = `NUM_BLOCKS
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             op_fail_inject
);

    localparam int AW = `ARRAY_ADDR_BITS;
    localparam int WORDS = 1 << AW;

    // ****************************************
    // State.
    // ****************************************
    typedef struct packed {
        logic                     dphase;
        logic                     dwrite;
        logic [15:0]              daddr;
        logic [31:0]              rdata;
        flash_seq_pkg::read_mode_e mode;
        flash_seq_pkg::op_e       first_cmd;
        logic [15:0]              first_addr;
        flash_seq_pkg::op_e       op;
        logic [AW-1:0]            op_addr;
        logic [15:0]              op_data;
        logic [3:0]               op_block;
        logic                     ready;
        logic                     erase_err;
        logic                     prog_err;
        logic                     lock_disable;
        logic                     ew_mode_one;
        logic                     clk_stop;
        logic                     lock_result;
        logic                     fail_inject;
        logic [NUM_BLOCKS-1:0]    lock_bits;
    } seq_s;

    seq_s state;
    seq_s next_state;

    logic [15:0] array_mem [WORDS];
    logic        mem_we;
    logic [AW-1:0] mem_waddr;
    logic [15:0] mem_wdata;
    logic        erase_we;
    logic [3:0]  erase_block;
    logic        timer_start;
    logic [15:0] timer_load;
    logic        timer_done;

    // ****************************************
    // Helpers.
    // ****************************************
    function automatic logic [3:0] block_of(input logic [15:0] addr);
        return 4'(addr[AW:1] >> `BLOCK_WORDS_LOG2);
    endfunction

    function automatic logic is_block_top(input logic [15:0] addr);
        return &addr[`BLOCK_WORDS_LOG2:1];
    endfunction

    function automatic logic in_rom(input logic [15:0] addr);
        return (addr & `ROM_BASE) != 16'h0000;
    endfunction

    function automatic logic [7:0] status_of(input seq_s s);
        logic [7:0] b;
        b = 8'h00;
        b[`SR_READY_BIT] = s.ready;
        b[`SR_ERASE_ERR_BIT] = s.erase_err;
        b[`SR_PROG_ERR_BIT] = s.prog_err;
        return b;
    endfunction

    op_timer #(
        .WIDTH(16)
    ) u_timer (
        .hclk    (hclk),
        .hresetn (hresetn),
        .start   (timer_start),
        .load    (timer_load),
        .done    (timer_done)
    );

    // ****************************************
    // Command decode and sequencing.
    // ****************************************
    always_comb begin
        logic        take;
        logic [15:0] wd;
        logic [7:0]  code;
        logic        locked;
        logic        errs;
        take = 1'b0;
        wd = hwdata[15:0];
        code = hwdata[7:0];
        locked = 1'b0;
        errs = state.erase_err | state.prog_err;
        next_state = state;
        mem_we = 1'b0;
        mem_waddr = state.op_addr;
        mem_wdata = state.op_data;
        erase_we = 1'b0;
        erase_block = state.op_block;
        timer_start = 1'b0;
        timer_load = 16'(PROGRAM_CYCLES);

        take = hsel && hready && htrans[1];
        next_state.dphase = take;
        if (take) begin
            next_state.dwrite = hwrite;
            next_state.daddr = haddr[15:0];
        end

        // Data phase of a register or array write.
        if (state.dphase && state.dwrite && !in_rom(state.daddr)) begin
            if (state.daddr == `CTRL_A_OFFSET) begin
                next_state.lock_disable = hwdata[`CA_LOCK_DISABLE_BIT];
            end else if (state.daddr == `CTRL_B_OFFSET) begin
                next_state.ew_mode_one = hwdata[`CB_EW_MODE_BIT];
                next_state.clk_stop = hwdata[`CB_CLK_STOP_BIT];
                next_state.fail_inject = hwdata[31];
            end
        end else if (state.dphase && state.dwrite && state.ready && !state.daddr[0]) begin
            if (state.mode == flash_seq_pkg::MODE_SECOND) begin
                next_state.mode = flash_seq_pkg::MODE_ARRAY;
                locked = !state.lock_disable && !state.lock_bits[block_of(state.daddr)];
                unique case (state.first_cmd)
                    flash_seq_pkg::OP_PROGRAM: begin
                        if (locked) begin
                            next_state.prog_err = 1'b1;
                        end else begin
                            next_state.op = flash_seq_pkg::OP_PROGRAM;
                            next_state.op_addr = state.daddr[AW:1];
                            next_state.op_data = wd;
                            next_state.ready = 1'b0;
                            timer_start = 1'b1;
                        end
                        if (!state.ew_mode_one) begin
                            next_state.mode = flash_seq_pkg::MODE_STATUS;
                        end
                    end
                    default: begin
                        if (code == `CMD_READ_ARRAY) begin
                            next_state.mode = flash_seq_pkg::MODE_ARRAY;
                        end else if (code != `CMD_CONFIRM) begin
                            next_state.erase_err = 1'b1;
                            next_state.prog_err = 1'b1;
                            if (!state.ew_mode_one) begin
                                next_state.mode = flash_seq_pkg::MODE_STATUS;
                            end
                        end else begin
                            next_state.op_block = block_of(state.daddr);
                            next_state.ready = 1'b0;
                            timer_start = 1'b1;
                            timer_load = 16'(ERASE_CYCLES);
                            next_state.op = state.first_cmd;
                            if (state.first_cmd == flash_seq_pkg::OP_ERASE_ALL) begin
                                next_state.op_block = 4'd0;
                            end
                            if (state.first_cmd == flash_seq_pkg::OP_ERASE && locked) begin
                                next_state.op = flash_seq_pkg::OP_IDLE;
                                next_state.ready = 1'b1;
                                next_state.erase_err = 1'b1;
                                timer_start = 1'b0;
                            end
                            if (state.first_cmd == flash_seq_pkg::OP_READ_LOCK) begin
                                timer_load = 16'd1;
                            end
                            if (!state.ew_mode_one &&
                                state.first_cmd != flash_seq_pkg::OP_READ_LOCK) begin
                                next_state.mode = flash_seq_pkg::MODE_STATUS;
                            end
                        end
                    end
                endcase
            end else begin
                next_state.first_addr = state.daddr;
                unique case (code)
                    `CMD_READ_ARRAY: next_state.mode = flash_seq_pkg::MODE_ARRAY;
                    `CMD_READ_STATUS: next_state.mode = flash_seq_pkg::MODE_STATUS;
                    `CMD_CLEAR_STATUS: begin
                        next_state.erase_err = 1'b0;
                        next_state.prog_err = 1'b0;
                    end
                    `CMD_PROGRAM: begin
                        if (!errs) begin
                            next_state.first_cmd = flash_seq_pkg::OP_PROGRAM;
                            next_state.mode = flash_seq_pkg::MODE_SECOND;
                        end
                    end
                    `CMD_BLOCK_ERASE: begin
                        if (!errs) begin
                            next_state.first_cmd = flash_seq_pkg::OP_ERASE;
                            next_state.mode = flash_seq_pkg::MODE_SECOND;
                        end
                    end
                    `CMD_ERASE_ALL: begin
                        if (!errs) begin
                            next_state.first_cmd = flash_seq_pkg::OP_ERASE_ALL;
                            next_state.mode = flash_seq_pkg::MODE_SECOND;
                        end
                    end
                    `CMD_LOCK_PROGRAM: begin
                        if (!errs) begin
                            next_state.first_cmd = flash_seq_pkg::OP_LOCK_PROGRAM;
                            next_state.mode = flash_seq_pkg::MODE_SECOND;
                        end
                    end
                    `CMD_READ_LOCK: begin
                        next_state.first_cmd = flash_seq_pkg::OP_READ_LOCK;
                        next_state.mode = flash_seq_pkg::MODE_SECOND;
                    end
                    default: begin
                        next_state.mode = state.mode;
                    end
                endcase
            end
        end

        // Completion of a timed step.
        if (timer_done) begin
            unique case (state.op)
                flash_seq_pkg::OP_PROGRAM: begin
                    mem_we = !state.fail_inject;
                    next_state.prog_err = state.fail_inject;
                    next_state.ready = 1'b1;
                    next_state.op = flash_seq_pkg::OP_IDLE;
                end
                flash_seq_pkg::OP_ERASE: begin
                    erase_we = !state.fail_inject;
                    next_state.erase_err = state.fail_inject;
                    if (!state.fail_inject) begin
                        next_state.lock_bits[state.op_block] = 1'b1;
                    end
                    next_state.ready = 1'b1;
                    next_state.op = flash_seq_pkg::OP_IDLE;
                end
                flash_seq_pkg::OP_ERASE_ALL: begin
                    locked = !state.lock_disable && !state.lock_bits[state.op_block];
                    erase_we = !state.fail_inject && !locked;
                    if (!state.fail_inject && !locked) begin
                        next_state.lock_bits[state.op_block] = 1'b1;
                    end
                    if (state.fail_inject) begin
                        next_state.erase_err = 1'b1;
                    end
                    if (state.op_block == 4'(`BLOCK_A_INDEX - 1)) begin
                        next_state.ready = 1'b1;
                        next_state.op = flash_seq_pkg::OP_IDLE;
                    end else begin
                        next_state.op_block = state.op_block + 4'd1;
                        timer_start = 1'b1;
                        timer_load = 16'(ERASE_CYCLES);
                    end
                end
                flash_seq_pkg::OP_LOCK_PROGRAM: begin
                    if (state.fail_inject) begin
                        next_state.prog_err = 1'b1;
                    end else begin
                        next_state.lock_bits[state.op_block] = 1'b0;
                    end
                    next_state.ready = 1'b1;
                    next_state.op = flash_seq_pkg::OP_IDLE;
                end
                flash_seq_pkg::OP_READ_LOCK: begin
                    next_state.lock_result = state.lock_bits[state.op_block];
                    next_state.ready = 1'b1;
                    next_state.op = flash_seq_pkg::OP_IDLE;
                end
                default: begin
                    next_state.op = flash_seq_pkg::OP_IDLE;
                end
            endcase
        end

        // Read data for the next data phase.
        next_state.rdata = 32'h0000_0000;
        if (take && !hwrite) begin
            if (!in_rom(haddr[15:0])) begin
                if (haddr[15:0] == `CTRL_A_OFFSET) begin
                    next_state.rdata[`CA_READY_BIT] = next_state.ready;
                    next_state.rdata[`CA_LOCK_DISABLE_BIT] = next_state.lock_disable;
                    next_state.rdata[`CA_PROG_ERR_BIT] = next_state.prog_err;
                    next_state.rdata[`CA_ERASE_ERR_BIT] = next_state.erase_err;
                end else if (haddr[15:0] == `CTRL_B_OFFSET) begin
                    next_state.rdata[`CB_EW_MODE_BIT] = next_state.ew_mode_one;
                    next_state.rdata[`CB_LOCK_RESULT_BIT] = next_state.lock_result;
                    next_state.rdata[`CB_CLK_STOP_BIT] = next_state.clk_stop;
                end
            end else if (next_state.mode == flash_seq_pkg::MODE_STATUS) begin
                next_state.rdata = {24'h00_0000, status_of(next_state)};
            end else begin
                next_state.rdata = {16'h0000, array_mem[haddr[AW:1]]};
            end
        end
    end

    // ****************************************
    // Array storage, erased state all ones.
    // ****************************************
    always_ff @(posedge hclk) begin
        if (mem_we) begin
            array_mem[mem_waddr] <= mem_wdata & array_mem[mem_waddr];
        end
        if (erase_we) begin
            for (int i = 0; i < WORDS; i++) begin
                if (4'(i >> `BLOCK_WORDS_LOG2) == erase_block) begin
                    array_mem[i] <= 16'hFFFF;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= '0;
            state.mode <= flash_seq_pkg::MODE_ARRAY;
            state.first_cmd <= flash_seq_pkg::OP_IDLE;
            state.op <= flash_seq_pkg::OP_IDLE;
            state.ready <= 1'b1;
            state.lock_bits <= NUM_BLOCKS'(`LOCK_RESET);
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // Outputs.
    // ****************************************
    assign hrdata = state.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign op_fail_inject = state.fail_inject;

endmodule

// ===== verif/flash_seq_assertions.sv
// Port assertions for the flash command sequencer.
`include "flash_seq_defines.svh"
module flash_seq_assertions (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        op_fail_inject
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Data phase tracking.
    // ****************************************
    logic        d_v;
    logic        d_wr;
    logic [15:0] d_a;
    logic        wa;
    logic        wb;
    logic        ra;
    logic        rb;
    logic        wc;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            d_v <= 1'b0;
            d_wr <= 1'b0;
            d_a <= 16'h0000;
        end else if (hready) begin
            d_v <= hsel & htrans[1];
            d_wr <= hwrite;
            d_a <= haddr[15:0];
        end
    end
    assign wa = d_v && d_wr && d_a == `CTRL_A_OFFSET;
    assign wb = d_v && d_wr && d_a == `CTRL_B_OFFSET;
    assign ra = d_v && !d_wr && d_a == `CTRL_A_OFFSET;
    assign rb = d_v && !d_wr && d_a == `CTRL_B_OFFSET;
    assign wc = d_v && d_wr && d_a[15];
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_ready_const: assert property (hreadyout) else $error("hreadyout low");
    chk_resp_okay: assert property (!hresp) else $error("hresp not okay");
    chk_reset_rdata: assert property ($rose(hresetn) |-> hrdata == 32'h0000_0000)
        else $error("hrdata not clear after reset");
    chk_clear_flags: assert property (wc && hwdata[7:0] == 8'h50 ##3 ra |-> hrdata[7:6] == 2'b00)
        else $error("error flags survive clear");
    chk_inject_copy: assert property (wb |=> op_fail_inject == $past(hwdata[31]))
        else $error("inject bit not taken");
    chk_disable_back: assert property (wa ##3 ra |-> hrdata[2] == $past(hwdata[2], 3))
        else $error("lock disable readback wrong");
    chk_mode_back: assert property (wb ##3 rb |-> hrdata[1] == $past(hwdata[1], 3)
        && hrdata[8] == $past(hwdata[8], 3)) else $error("ctrl_b readback wrong");
    chk_unmapped_zero: assert property (d_v && !d_wr && !d_a[15] && d_a[15:3] != 13'h0000
        |-> hrdata == 32'h0000_0000) else $error("unmapped read not zero");
    cp_program: cover property (wc && hwdata[7:0] == 8'h40);
    cp_erase_all: cover property (wc && hwdata[7:0] == 8'hA7);
    cp_lock: cover property (wc && hwdata[7:0] == 8'h77);
endmodule

bind flash_command_sequencer flash_seq_assertions chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .op_fail_inject(op_fail_inject));

// ===== verif/cpu_bus_model.sv
// Bus master standing in for the processor that issues flash commands.
module cpu_bus_model (
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata,
    output logic             hung
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'hA5A5_5A5A;
        hung = 1'b0;
    end
    task automatic edge_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        if (n >= 64) hung <= 1'b1;
    endtask
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        edge_ready;
        hsel <= 1'b0;
        htrans <= 2'b00;
        haddr <= ~a;
        hwdata <= wr ? d : ~hwdata;
        edge_ready;
        q = hrdata;
        hwdata <= ~hwdata;
    endtask
endmodule

// ===== verif/tb_top.sv
// Self-checking bench for the flash command sequencer.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] CA = 32'h0000_0000;
    localparam logic [31:0] CB = 32'h0000_0004;
    localparam logic [31:0] R  = 32'h0000_8000;
    logic             hclk = 1'b0;
    logic             hresetn = 1'b0;
    wire logic        hsel, hwrite, hreadyout, hresp, op_fail_inject, hung;
    wire logic [31:0] haddr, hwdata, hrdata;
    wire logic [1:0]  htrans;
    wire logic [2:0]  hsize;
    int               err_count = 0;
    int               checks = 0;
    logic [7:0]       bad [3] = '{8'h20, 8'hA7, 8'h77};
    always #2 hclk = ~hclk;
    always @(posedge hung) begin
        err_count++;
        results();
    end
    cpu_bus_model cpu (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hung(hung));
    flash_command_sequencer #(.PROGRAM_CYCLES(4), .ERASE_CYCLES(8), .NUM_BLOCKS(14)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .op_fail_inject(op_fail_inject));
    // ****************************************
    // Access and checking tasks.
    // ****************************************
    function automatic logic [31:0] top(input int b);
        return R + 32'(b) * 32'h0000_0200 + 32'h0000_01FE;
    endfunction
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        logic [31:0] q;
        cpu.xfer(1'b1, a, {16'h0000, d}, q);
    endtask
    task automatic rd(input string n, input logic [31:0] a, input logic [15:0] m,
                      input logic [15:0] e);
        logic [31:0] q;
        cpu.xfer(1'b0, a, 32'h0000_0000, q);
        chk(n, {16'h0000, q[15:0] & m}, {16'h0000, e});
    endtask
    task automatic cmd(input logic [31:0] a1, input logic [15:0] d1, input logic [31:0] a2,
                       input logic [15:0] d2);
        wr(a1, d1);
        wr(a2, d2);
    endtask
    task automatic wait_ready;
        logic [31:0] q;
        for (int i = 0; i < 400; i++) begin
            cpu.xfer(1'b0, CA, 32'h0000_0000, q);
            if (q[0] === 1'b1) return;
        end
        err_count++;
        results();
    endtask
    task automatic done(input string n);
        $display("test %s finished", n);
    endtask
    task automatic results;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ****************************************
    // Test sequence.
    // ****************************************
    initial begin
        logic [31:0] q;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rd("ctrl_a", CA, 16'h00C5, 16'h0001);
        rd("unmapped", 32'h0000_0010, 16'hFFFF, 16'h0000);
        wr(CB, 16'h0102);
        rd("ctrl_b", CB, 16'h0102, 16'h0102);
        wr(CB, 16'h0000);
        done("reset");
        cmd(R, 16'hEE71, top(0), 16'h00D0);
        wait_ready;
        rd("lock_open", CB, 16'h0040, 16'h0040);
        cmd(R, 16'h0020, top(0), 16'h00D0);
        rd("busy", CA, 16'h0001, 16'h0000);
        rd("status_busy", R, 16'h0080, 16'h0000);
        wait_ready;
        rd("status_held", R, 16'h00B0, 16'h0080);
        rd("erase_ok", CA, 16'h00C1, 16'h0001);
        cmd(R + 4, 16'hAB40, R + 4, 16'h1234);
        wait_ready;
        wr(R, 16'h33FF);
        rd("program_data", R + 4, 16'hFFFF, 16'h1234);
        rd("program_ok", CA, 16'h00C1, 16'h0001);
        done("program");
        cmd(top(0), 16'h0077, top(0), 16'h00D0);
        wait_ready;
        cmd(R, 16'h0071, top(0), 16'h00D0);
        wait_ready;
        rd("lock_shut", CB, 16'h0040, 16'h0000);
        cmd(R + 8, 16'h0040, R + 8, 16'h0000);
        rd("locked_program", CA, 16'h00C1, 16'h0041);
        wr(R, 16'h0070);
        rd("status_err", R, 16'h00B0, 16'h0090);
        cmd(R, 16'h0020, top(1), 16'h00D0);
        rd("refused", CA, 16'h0001, 16'h0001);
        wr(R, 16'h0050);
        rd("cleared", CA, 16'h00C1, 16'h0001);
        wr(R, 16'h0070);
        rd("status_clear", R, 16'h00B0, 16'h0080);
        done("lock");
        wr(CA, 16'h0004);
        cmd(R, 16'h0020, top(0), 16'h00D0);
        wait_ready;
        rd("forced_erase", CA, 16'h00C5, 16'h0005);
        wr(CA, 16'h0000);
        rd("disable_off", CA, 16'h0004, 16'h0000);
        cmd(R, 16'h0071, top(0), 16'h00D0);
        wait_ready;
        rd("lock_reopened", CB, 16'h0040, 16'h0040);
        done("lock_disable");
        cmd(R, 16'h0020, top(13), 16'h00D0);
        wait_ready;
        cmd(top(13), 16'h0040, top(13), 16'h5AA5);
        wait_ready;
        cmd(R + 4, 16'h0040, R + 4, 16'h0000);
        wait_ready;
        cmd(R, 16'h00A7, R, 16'h00D0);
        wait_ready;
        wr(R, 16'h00FF);
        rd("block_a", top(13), 16'hFFFF, 16'h5AA5);
        rd("block_0", R + 4, 16'hFFFF, 16'hFFFF);
        done("erase_all");
        foreach (bad[i]) begin
            cmd(top(2), {8'h00, bad[i]}, top(2), 16'h0055);
            rd("sequence_error", CA, 16'h00C1, 16'h00C1);
            wr(R, 16'h0050);
        end
        cmd(R, 16'h0020, top(2), 16'h00FF);
        rd("escape", CA, 16'h00C1, 16'h0001);
        rd("escape_array", R + 4, 16'hFFFF, 16'hFFFF);
        done("second_cycle");
        cpu.xfer(1'b1, CB, 32'h8000_0002, q);
        #1;
        chk("inject", {31'h0000_0000, op_fail_inject}, 32'h0000_0001);
        cmd(R + 8, 16'h0040, R + 8, 16'h0F0F);
        wait_ready;
        rd("inject_fail", CA, 16'h00C1, 16'h0041);
        rd("mode_one", R + 8, 16'hFFFF, 16'hFFFF);
        done("inject");
        results();
    end
endmodule
